//--- src/operand_mode_defs.vh
// Constants for the operand addressing-mode decoder.
`ifndef OPERAND_MODE_DEFS_VH
`define OPERAND_MODE_DEFS_VH

// Mode code boundaries.
`define MODE_DIRECT_LAST    5'h07
`define MODE_INDIRECT_LAST  5'h0b
`define MODE_POSTINC_LAST   5'h0f
`define MODE_SHORT_OFFSET_LAST     5'h17
`define MODE_LONG_OFFSET_LAST    5'h1b
`define MODE_INDEX0         5'h1c
`define MODE_INDEX1         5'h1d
`define MODE_PCREL          5'h1e
`define MODE_ABS            5'h1f

// Mode classes.
`define CLS_DIRECT          3'h0
`define CLS_INDIRECT        3'h1
`define CLS_POSTINC         3'h2
`define CLS_SHORT_OFFSET           3'h3
`define CLS_LONG_OFFSET          3'h4
`define CLS_INDEX           3'h5
`define CLS_PCREL           3'h6
`define CLS_ABS             3'h7

// Operand sizes.
`define SIZE_BYTE           2'h0
`define SIZE_WORD           2'h1
`define SIZE_LONG           2'h2

// Operand targets.
`define TGT_REG             2'h0
`define TGT_IMEM            2'h1
`define TGT_EXT16           2'h2
`define TGT_EXT8            2'h3

// Fixed index register for the indexed modes.
`define INDEX_REG_NUM       3'h7

// Addressing costs.
`define CYC_INDIRECT        4'h2
`define CYC_POSTINC         4'h4
`define CYC_DISP            4'h2
`define CYC_INDEX           4'h4
`define CYC_PCREL           4'h2
`define CYC_ABS             4'h1
`define ACC_ONE             3'h1
`define ACC_TWO             3'h2

// Program fetch corrections.
`define FETCH_IMEM_WORD     4'h2
`define FETCH_EXT16_WORD    4'h3
`define FETCH_EXT8_BYTE     4'h3

`endif

//--- src/operand_cost_table.v
// Operand size and target compensation lookup.
`timescale 1ns/1ps
`default_nettype none
`include "operand_mode_defs.vh"
module operand_cost_table (
	// Operand description.
	input  wire [1:0] size_in,
	input  wire [1:0] target_in,
	input  wire       odd_in,
	// Compensation.
	output reg  [3:0] cycles_out,
	output reg  [2:0] access_out
);
	always @* begin
		cycles_out = 4'h0;
		access_out = 3'h1;
		case (size_in)
		`SIZE_BYTE: begin
			if (target_in != `TGT_REG && target_in != `TGT_IMEM) begin
				cycles_out = 4'h1;
			end
		end
		`SIZE_WORD: begin
			case (target_in)
			`TGT_REG: ;
			`TGT_IMEM: begin
				if (odd_in) begin
					cycles_out = 4'h2;
					access_out = 3'h2;
				end
			end
			`TGT_EXT16: begin
				if (odd_in) begin
					cycles_out = 4'h4;
					access_out = 3'h2;
				end else begin
					cycles_out = 4'h1;
				end
			end
			default: begin
				cycles_out = 4'h4;
				access_out = 3'h2;
			end
			endcase
		end
		default: begin
			access_out = 3'h2;
			case (target_in)
			`TGT_REG: ;
			`TGT_IMEM: begin
				if (odd_in) begin
					cycles_out = 4'h4;
					access_out = 3'h4;
				end
			end
			`TGT_EXT16: begin
				if (odd_in) begin
					cycles_out = 4'h8;
					access_out = 3'h4;
				end else begin
					cycles_out = 4'h2;
				end
			end
			default: begin
				cycles_out = 4'h8;
				access_out = 3'h4;
			end
			endcase
		end
		endcase
	end
endmodule
`default_nettype wire

//--- src/fetch_correction.v
// Program fetch cycle correction for one instruction.
`timescale 1ns/1ps
`default_nettype none
`include "operand_mode_defs.vh"
module fetch_correction (
	// Fetch description.
	input  wire [1:0] target_in,
	input  wire [2:0] word_cross_in,
	input  wire [3:0] length_in,
	// Correction.
	output reg  [5:0] cycles_out
);
	// Registers as a target never hold code, so they cost nothing here.
	always @* begin
		case (target_in)
		`TGT_IMEM:  cycles_out = {3'h0, word_cross_in} * {2'h0, `FETCH_IMEM_WORD};
		`TGT_EXT16: cycles_out = {3'h0, word_cross_in} * {2'h0, `FETCH_EXT16_WORD};
		`TGT_EXT8:  cycles_out = {2'h0, length_in} * {2'h0, `FETCH_EXT8_BYTE};
		default:    cycles_out = 6'h00;
		endcase
	end
endmodule
`default_nettype wire

//--- src/operand_address_mode_decoder.v
// Operand addressing-mode decoder with cycle accounting.
// Notes on behaviour
// - Codes 00-07 pick byte, word or long register.
// - Codes 0C-0F: pointer indirect, post-increment, 4 cycles.
// - Codes 10-17: word register plus short offset.
// - Codes 18-1B: pointer plus long offset.
// - Codes 1C-1D: register 0/1 plus index register.
// - 1E PC-relative, 1F absolute, no registers.
// - Report extension bytes; indirect modes add none.
// - Memory modes add cycles; all but 1E/1F add register accesses.
// - Byte operands: one access, external adds one.
// - Odd internal word/long: split accesses, extra cycles.
// - Long internal two accesses; even word one.
// - External 16-bit even: word +1, long +2.
// - Odd ext16 or ext8: word +4, long +8.
// - Fetch corrections per boundary or per byte.
// - Fetch corrections are worst-case bounds only.
`timescale 1ns/1ps
`default_nettype none
`include "operand_mode_defs.vh"
module operand_address_mode_decoder (
	// Clock and reset.
	input  wire        sys_clk_in,
	input  wire        sys_rst_in,
	// Decode request.
	input  wire        decode_valid_in,
	input  wire [4:0]  mode_code_in,
	input  wire [1:0]  op_size_in,
	input  wire [1:0]  op_target_in,
	input  wire        op_odd_in,
	input  wire [5:0]  base_states_in,
	input  wire [3:0]  insn_length_in,
	input  wire [2:0]  word_cross_in,
	input  wire [3:0]  wait_cycles_in,
	// Decode result.
	output reg         result_valid_out,
	output reg  [2:0]  mode_class_out,
	output reg  [2:0]  base_reg_out,
	output reg         base_is_byte_out,
	output reg         base_is_word_out,
	output reg         base_is_long_out,
	output reg         index_used_out,
	output reg  [2:0]  index_reg_out,
	output reg         pc_base_out,
	output reg         post_inc_out,
	output reg  [2:0]  post_inc_step_out,
	output reg  [1:0]  ext_bytes_out,
	output reg  [3:0]  insn_total_len_out,
	output reg  [3:0]  mode_cycles_out,
	output reg  [2:0]  mode_reg_access_out,
	output reg  [3:0]  size_cycles_out,
	output reg  [2:0]  data_access_out,
	output reg  [5:0]  fetch_worst_out,
	output reg  [7:0]  total_states_out
);
	reg  [2:0] cls_d;
	reg  [2:0] reg_d;
	reg  [1:0] ext_d;
	reg  [3:0] mcyc_d;
	reg  [2:0] macc_d;
	reg  [2:0] step_d;
	wire [3:0] scyc_w;
	wire [2:0] sacc_w;
	wire [5:0] fetch_w;
	reg  [3:0] wait_d;
	reg  [7:0] total_d;

	// Maps a mode code onto its class.
	function [2:0] mode_class;
		input [4:0] code;
		begin
			if (code <= `MODE_DIRECT_LAST)
				mode_class = `CLS_DIRECT;
			else if (code <= `MODE_INDIRECT_LAST)
				mode_class = `CLS_INDIRECT;
			else if (code <= `MODE_POSTINC_LAST)
				mode_class = `CLS_POSTINC;
			else if (code <= `MODE_SHORT_OFFSET_LAST)
				mode_class = `CLS_SHORT_OFFSET;
			else if (code <= `MODE_LONG_OFFSET_LAST)
				mode_class = `CLS_LONG_OFFSET;
			else if (code == `MODE_PCREL)
				mode_class = `CLS_PCREL;
			else if (code == `MODE_ABS)
				mode_class = `CLS_ABS;
			else
				mode_class = `CLS_INDEX;
		end
	endfunction

	operand_cost_table u_cost (
		.size_in    (op_size_in),
		.target_in  (op_target_in),
		.odd_in     (op_odd_in),
		.cycles_out (scyc_w),
		.access_out (sacc_w)
	);

	fetch_correction u_fetch (
		.target_in     (op_target_in),
		.word_cross_in (word_cross_in),
		.length_in     (insn_length_in),
		.cycles_out    (fetch_w)
	);

	always @* begin
		cls_d  = mode_class(mode_code_in);
		reg_d  = mode_code_in[2:0];
		ext_d  = 2'h0;
		mcyc_d = 4'h0;
		macc_d = 3'h0;
		step_d = 3'h0;
		case (cls_d)
		`CLS_DIRECT: begin
			// Long registers pair up, so odd codes name the same pair.
			// Size code 3 is taken as long here, as the cost table does.
			if (op_size_in >= `SIZE_LONG)
				reg_d = {1'b0, mode_code_in[2:1]};
			else
				reg_d = mode_code_in[2:0];
		end
		`CLS_INDIRECT: begin
			reg_d  = {1'b0, mode_code_in[1:0]};
			ext_d  = 2'h0;
			mcyc_d = `CYC_INDIRECT;
			macc_d = `ACC_ONE;
		end
		`CLS_POSTINC: begin
			reg_d  = {1'b0, mode_code_in[1:0]};
			mcyc_d = `CYC_POSTINC;
			macc_d = `ACC_TWO;
			case (op_size_in)
			`SIZE_BYTE: step_d = 3'h1;
			`SIZE_WORD: step_d = 3'h2;
			default:    step_d = 3'h4;
			endcase
		end
		`CLS_SHORT_OFFSET: begin
			reg_d  = mode_code_in[2:0];
			ext_d  = 2'h1;
			mcyc_d = `CYC_DISP;
			macc_d = `ACC_ONE;
		end
		`CLS_LONG_OFFSET: begin
			reg_d  = {1'b0, mode_code_in[1:0]};
			ext_d  = 2'h2;
			mcyc_d = `CYC_DISP;
			macc_d = `ACC_ONE;
		end
		`CLS_INDEX: begin
			reg_d  = {2'h0, mode_code_in[0]};
			mcyc_d = `CYC_INDEX;
			macc_d = `ACC_TWO;
		end
		`CLS_PCREL: begin
			reg_d  = 3'h0;
			ext_d  = 2'h2;
			mcyc_d = `CYC_PCREL;
		end
		default: begin
			reg_d  = 3'h0;
			ext_d  = 2'h2;
			mcyc_d = `CYC_ABS;
		end
		endcase
		// Waits only stretch external data bus accesses.
		if (op_target_in == `TGT_EXT16 || op_target_in == `TGT_EXT8)
			wait_d = wait_cycles_in;
		else
			wait_d = 4'h0;
		// The fetch term is a worst case; the sum is an upper bound.
		total_d = {2'h0, base_states_in} + {4'h0, mcyc_d} + {4'h0, scyc_w}
			+ {2'h0, fetch_w} + {4'h0, wait_d};
	end

	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			result_valid_out    <= 1'b0;
			mode_class_out      <= 3'h0;
			base_reg_out        <= 3'h0;
			base_is_byte_out    <= 1'b0;
			base_is_word_out    <= 1'b0;
			base_is_long_out    <= 1'b0;
			index_used_out      <= 1'b0;
			index_reg_out       <= 3'h0;
			pc_base_out         <= 1'b0;
			post_inc_out        <= 1'b0;
			post_inc_step_out   <= 3'h0;
			ext_bytes_out       <= 2'h0;
			insn_total_len_out  <= 4'h0;
			mode_cycles_out     <= 4'h0;
			mode_reg_access_out <= 3'h0;
			size_cycles_out     <= 4'h0;
			data_access_out     <= 3'h0;
			fetch_worst_out     <= 6'h00;
			total_states_out    <= 8'h00;
		end else begin
			result_valid_out <= decode_valid_in;
			if (decode_valid_in) begin
				mode_class_out      <= cls_d;
				base_reg_out        <= reg_d;
				base_is_byte_out    <= (cls_d == `CLS_DIRECT) && (op_size_in == `SIZE_BYTE);
				base_is_word_out    <= (cls_d == `CLS_DIRECT) ? (op_size_in == `SIZE_WORD)
					: (cls_d != `CLS_PCREL) && (cls_d != `CLS_ABS);
				base_is_long_out    <= (cls_d == `CLS_DIRECT) && (op_size_in >= `SIZE_LONG);
				index_used_out      <= (cls_d == `CLS_INDEX);
				index_reg_out       <= (cls_d == `CLS_INDEX) ? `INDEX_REG_NUM : 3'h0;
				pc_base_out         <= (cls_d == `CLS_PCREL);
				post_inc_out        <= (cls_d == `CLS_POSTINC);
				post_inc_step_out   <= step_d;
				ext_bytes_out       <= ext_d;
				insn_total_len_out  <= insn_length_in + {2'h0, ext_d};
				mode_cycles_out     <= mcyc_d;
				mode_reg_access_out <= macc_d;
				size_cycles_out     <= scyc_w;
				data_access_out     <= sacc_w;
				fetch_worst_out     <= fetch_w;
				total_states_out    <= total_d;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/operand_mode_assertions.sv
// Port checker for the operand addressing-mode decoder.
`timescale 1ns/1ps
`default_nettype none
module operand_mode_checker (
	// Clock, reset and request.
	input wire logic       sys_clk_in,
	input wire logic       sys_rst_in,
	input wire logic       decode_valid_in,
	input wire logic [4:0] mode_code_in,
	input wire logic [3:0] insn_length_in,
	// Result.
	input wire logic       result_valid_out,
	input wire logic [2:0] mode_class_out,
	input wire logic [2:0] base_reg_out,
	input wire logic       index_used_out,
	input wire logic [2:0] index_reg_out,
	input wire logic       post_inc_out,
	input wire logic [1:0] ext_bytes_out,
	input wire logic [3:0] insn_total_len_out,
	input wire logic [3:0] mode_cycles_out,
	input wire logic [2:0] mode_reg_access_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// A request is only taken with reset low, so the last reset edge starts no attempt.
	valid_latency_a: assert property (decode_valid_in && !sys_rst_in |=> result_valid_out)
		else $error("result missing one cycle after request");
	no_spurious_a: assert property (!decode_valid_in |=> !result_valid_out)
		else $error("result without request");
	postinc_cost_a: assert property (decode_valid_in && !sys_rst_in
		&& mode_code_in[4:2] == 3'b011
		|=> post_inc_out && mode_cycles_out == 4'h4 && mode_reg_access_out == 3'h2
		&& ext_bytes_out == 2'h0) else $error("post-increment cost wrong");
	short_disp_a: assert property (decode_valid_in && !sys_rst_in
		&& mode_code_in[4:3] == 2'b10
		|=> mode_class_out == 3'h3 && ext_bytes_out == 2'h1 && mode_cycles_out == 4'h2
		&& mode_reg_access_out == 3'h1) else $error("short offset mode wrong");
	long_disp_a: assert property (decode_valid_in && !sys_rst_in
		&& mode_code_in[4:2] == 3'b110
		|=> mode_class_out == 3'h4 && ext_bytes_out == 2'h2 && mode_cycles_out == 4'h2)
		else $error("long offset mode wrong");
	index_mode_a: assert property (decode_valid_in && !sys_rst_in
		&& mode_code_in[4:1] == 4'b1110
		|=> index_used_out && index_reg_out == 3'h7 && mode_cycles_out == 4'h4
		&& base_reg_out == {2'h0, $past(mode_code_in[0])}) else $error("index mode wrong");
	abs_mode_a: assert property (decode_valid_in && !sys_rst_in
		&& mode_code_in == 5'h1f
		|=> mode_cycles_out == 4'h1 && mode_reg_access_out == 3'h0 && ext_bytes_out == 2'h2)
		else $error("absolute mode wrong");
	total_len_a: assert property (result_valid_out
		|-> insn_total_len_out == $past(insn_length_in) + {2'h0, ext_bytes_out})
		else $error("total length wrong");
endmodule
bind operand_address_mode_decoder operand_mode_checker i_chk (.*);
`default_nettype wire

//--- sim/operand_address_mode_decoder_tb.sv
// Self-checking bench for the operand addressing-mode decoder.
`timescale 1ns/1ps
`default_nettype none
module operand_address_mode_decoder_tb;
	logic       sys_clk_in = 1'b0;
	logic       sys_rst_in = 1'b1;
	logic       decode_valid_in = 1'b0;
	logic       op_odd_in = 1'b0;
	logic [4:0] mode_code_in = 5'h00;
	logic [1:0] op_size_in = 2'h0;
	logic [1:0] op_target_in = 2'h0;
	logic [5:0] base_states_in = 6'h00;
	logic [3:0] insn_length_in = 4'h0;
	logic [2:0] word_cross_in = 3'h0;
	logic [3:0] wait_cycles_in = 4'h0;
	wire result_valid_out, base_is_byte_out, base_is_word_out, base_is_long_out;
	wire index_used_out, pc_base_out, post_inc_out;
	wire [2:0] mode_class_out, base_reg_out, index_reg_out, post_inc_step_out;
	wire [2:0] mode_reg_access_out, data_access_out;
	wire [3:0] insn_total_len_out, mode_cycles_out, size_cycles_out;
	wire [1:0] ext_bytes_out;
	wire [5:0] fetch_worst_out;
	wire [7:0] total_states_out;
	int errors = 0, num_checks = 0, ev = 0, go = 0, x = 1586, tot = 0;
	int c, s, t, a, cls, sc, sa, fe, len, stp, br;
	int ext_t[8] = '{0, 0, 0, 1, 2, 0, 2, 2};
	int mc_t[8] = '{0, 2, 4, 2, 2, 4, 2, 1};
	int ma_t[8] = '{0, 1, 2, 1, 1, 2, 0, 0};

	operand_address_mode_decoder i_dut (.*);

	initial forever #50 sys_clk_in = ~sys_clk_in;

	function automatic int rnd(input int v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task automatic chk(input string n, input int e, input logic [7:0] g);
		num_checks++;
		if (g !== e[7:0]) begin
			errors++;
			$display("CHECK FAILED %s exp %0d got %0d", n, e, g);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Model runs on the inputs as the decoder samples them, before this edge's updates land.
	always @(posedge sys_clk_in) begin
		ev = decode_valid_in & !sys_rst_in;
		if (sys_rst_in)
			tot = 0;
		if (ev) begin
			c = mode_code_in;
			s = op_size_in == 0 ? 0 : op_size_in == 1 ? 1 : 2;
			t = op_target_in;
			a = s == 2 ? 2 : 1;
			cls = c < 8 ? 0 : c < 12 ? 1 : c < 16 ? 2 : c < 24 ? 3 : c < 28 ? 4 : c < 30 ? 5 : c - 24;
			sa = (s != 0 && (t == 3 || (t != 0 && op_odd_in))) ? 2 * a : a;
			sc = sa > a ? (t == 1 ? 2 * a : 4 * a) : (t >= 2 ? a : 0);
			fe = t == 0 ? 0 : t == 1 ? 2 * word_cross_in : t == 2 ? 3 * word_cross_in
				: 3 * insn_length_in;
			tot = base_states_in + mc_t[cls] + sc + fe + (t >= 2 ? wait_cycles_in : 0);
			len = (insn_length_in + ext_t[cls]) % 16;
			stp = cls == 2 ? (s == 0 ? 1 : 2 * s) : 0;
			br = cls == 0 ? (s == 2 ? c / 2 % 4 : c % 8) : cls == 5 ? c % 2 : cls > 5 ? 0
				: cls == 3 ? c % 8 : c % 4;
		end
	end

	always @(negedge sys_clk_in) begin
		if (go) begin
			chk("valid", ev, result_valid_out);
			chk("total", tot, total_states_out);
			if (ev) begin
				chk("class", cls, mode_class_out);
				chk("ext", ext_t[cls], ext_bytes_out);
				chk("len", len, insn_total_len_out);
				chk("mcyc", mc_t[cls], mode_cycles_out);
				chk("macc", ma_t[cls], mode_reg_access_out);
				chk("scyc", sc, size_cycles_out);
				chk("sacc", sa, data_access_out);
				chk("fetch", fe, fetch_worst_out);
				chk("step", stp, post_inc_step_out);
				chk("breg", br, base_reg_out);
				chk("long", cls == 0 && s == 2, base_is_long_out);
				chk("byte", cls == 0 && s == 0, base_is_byte_out);
				chk("word", cls == 0 ? s == 1 : cls < 6, base_is_word_out);
				chk("index", cls == 5 ? 7 : 0, index_reg_out);
				chk("iused", cls == 5, index_used_out);
				chk("pinc", cls == 2, post_inc_out);
				chk("pcrel", cls == 6, pc_base_out);
			end
		end
	end

	// Walks every code, size, target and parity for n of 1024 or more, with random gaps and random counts.
	task automatic drive(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(posedge sys_clk_in);
			x = rnd(x);
			decode_valid_in <= x[1:0] != 2'h0;
			mode_code_in <= k[4:0];
			op_size_in <= k[6:5];
			op_target_in <= k[8:7];
			op_odd_in <= k[9];
			base_states_in <= x[9:4];
			insn_length_in <= x[13:10];
			word_cross_in <= x[16:14];
			wait_cycles_in <= x[20:17];
			if (x[1:0] != 2'h0)
				k++;
		end
	endtask

	initial begin
		repeat (4) @(posedge sys_clk_in);
		go = 1;
		sys_rst_in <= 1'b0;
		drive(1024);
		$display("test sweep done");
		@(posedge sys_clk_in);
		sys_rst_in <= 1'b1;
		decode_valid_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		drive(256);
		@(posedge sys_clk_in);
		decode_valid_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		$display("test reset and resume done");
		test_done;
	end

	initial begin
		#400000;
		errors++;
		test_done;
	end
endmodule
`default_nettype wire
